// ===== rtl/adcc_pkg.sv
package adcc_pkg;
    // calibration register file
    localparam int CAL_NUM = 10;
    localparam int CAL_DW = 14;
    localparam logic [3:0] IDX_GAIN = 4'h0;
    localparam logic [3:0] IDX_OFFSET = 4'h1;
    localparam logic [3:0] IDX_LAST = 4'h9;
    localparam logic [13:0] OFFSET_RST = 14'h2000;
    localparam logic [13:0] GAIN_RST = 14'h2000;
    localparam logic [13:0] DAC_RST = 14'h0000;
    // calibration select codes
    localparam logic [1:0] SEL_ALL = 2'h0;
    localparam logic [1:0] SEL_GAIN_OFS = 2'h1;
    localparam logic [1:0] SEL_OFS = 2'h2;
    localparam logic [1:0] SEL_GAIN = 2'h3;
    // read target codes
    localparam logic [1:0] RDT_RESULT = 2'h0;
    localparam logic [1:0] RDT_CTRL = 2'h1;
    localparam logic [1:0] RDT_CAL = 2'h2;
    localparam logic [1:0] RDT_STATUS = 2'h3;
    // control word fields
    localparam int CTL_CONV = 0;
    localparam int CTL_STCAL = 1;
    localparam int CTL_CALSEL = 2;
    localparam int CTL_CALMD = 4;
    localparam int CTL_RDT = 5;
    localparam int CTL_MARK = 15;
    // status word fields
    localparam int ST_STCAL = 0;
    localparam int ST_CALSEL = 1;
    localparam int ST_CALMD = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_ONES = 6;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS = 10;
    localparam logic [15:0] SETUP_CYC = 16'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // conversion length in master clock half periods: 16.5 and 17.5 periods
    localparam logic [15:0] HALVES_FAST = 16'h0021;
    localparam logic [15:0] HALVES_SLOW = 16'h0023;
    typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_RUN} adcc_tmr_state_t;
endpackage : adcc_pkg

// ===== rtl/adcc_calrf.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_calrf (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // async reset
    input wire logic [1:0] sel_i, // calibration select
    input wire logic ptr_rst_i, // pointer back to start
    input wire logic adv_i, // one register fully accessed
    input wire logic wr_i, // host write at pointer
    input wire logic [13:0] wr_data_i, // host write data
    input wire logic hw_we_i, // calibration engine write
    input wire logic [3:0] hw_idx_i, // calibration engine index
    input wire logic [13:0] hw_data_i, // calibration engine data
    output logic [15:0] rd_data_o, // register at pointer
    output logic [3:0] ptr_o // pointer
);
    typedef struct packed {
        logic [adcc_pkg::CAL_NUM-1:0][adcc_pkg::CAL_DW-1:0] regs;
        logic [3:0] ptr;
    } adcc_rf_st_t;
    adcc_rf_st_t r, s;
    logic [3:0] first, last;
    always_comb begin
        first = (sel_i == adcc_pkg::SEL_OFS) ? adcc_pkg::IDX_OFFSET : adcc_pkg::IDX_GAIN;
        case (sel_i)
            adcc_pkg::SEL_ALL: last = adcc_pkg::IDX_LAST;
            adcc_pkg::SEL_GAIN_OFS: last = adcc_pkg::IDX_OFFSET;
            adcc_pkg::SEL_OFS: last = adcc_pkg::IDX_OFFSET;
            default: last = adcc_pkg::IDX_GAIN;
        endcase
        s = r;
        if (wr_i) begin
            s.regs[r.ptr] = wr_data_i;
        end
        if (hw_we_i && hw_idx_i <= adcc_pkg::IDX_LAST) begin
            s.regs[hw_idx_i] = hw_data_i;
        end
        if (ptr_rst_i) begin
            s.ptr = first;
        end else if (adv_i) begin
            s.ptr = (r.ptr == last) ? first : r.ptr + 4'h1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r.regs <= '0;
            r.regs[adcc_pkg::IDX_GAIN] <= adcc_pkg::GAIN_RST;
            r.regs[adcc_pkg::IDX_OFFSET] <= adcc_pkg::OFFSET_RST;
            r.ptr <= adcc_pkg::IDX_GAIN;
        end else begin
            r <= s;
        end
    end
    assign rd_data_o = {2'b00, r.regs[r.ptr]};
    assign ptr_o = r.ptr;

    property p_ptr_first;
        @(posedge clk_i) disable iff (rst_i)
        ptr_rst_i |=> ptr_o == (($past(sel_i) == adcc_pkg::SEL_OFS) ? adcc_pkg::IDX_OFFSET : adcc_pkg::IDX_GAIN);
    endproperty
    a_ptr_first: assert property (p_ptr_first) else $error("pointer start wrong");
    property p_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (adv_i && !ptr_rst_i && sel_i == adcc_pkg::SEL_GAIN_OFS && ptr_o == adcc_pkg::IDX_OFFSET)
            |=> ptr_o == adcc_pkg::IDX_GAIN;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
    property p_incr;
        @(posedge clk_i) disable iff (rst_i)
        (adv_i && !ptr_rst_i && sel_i == adcc_pkg::SEL_ALL && ptr_o != adcc_pkg::IDX_LAST)
            |=> ptr_o == $past(ptr_o) + 4'h1;
    endproperty
    a_incr: assert property (p_incr) else $error("pointer did not advance");
    property p_zeros;
        @(posedge clk_i) disable iff (rst_i)
        rd_data_o[15:14] == 2'b00;
    endproperty
    a_zeros: assert property (p_zeros) else $error("leading bits not zero");
endmodule : adcc_calrf
`default_nettype wire

// ===== rtl/adcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_timer #(
    parameter logic [15:0] CAL_HALVES = 16'h0040 // calibration length in half periods
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // async reset
    input wire logic start_i, // start request
    input wire logic cal_i, // request is a calibration
    input wire logic mck_rise_i, // master clock rising edge
    input wire logic mck_fall_i, // master clock falling edge
    output logic busy_o, // conversion or calibration running
    output logic cal_o, // calibration running
    output logic done_o // one cycle at the end
);
    typedef struct packed {
        adcc_pkg::adcc_tmr_state_t st;
        logic [15:0] cnt;
        logic is_cal;
        logic busy;
        logic done;
    } adcc_tmr_st_t;
    adcc_tmr_st_t r, s;
    always_comb begin
        s = r;
        s.done = 1'b0;
        case (r.st)
            adcc_pkg::TS_IDLE: begin
                if (start_i) begin
                    s.st = adcc_pkg::TS_WAIT;
                    s.cnt = '0;
                    s.is_cal = cal_i;
                    s.busy = 1'b1;
                end
            end
            adcc_pkg::TS_WAIT: begin
                if (mck_fall_i) begin
                    s.st = adcc_pkg::TS_RUN;
                    if (r.is_cal) begin
                        s.cnt = CAL_HALVES;
                    end else if (r.cnt >= adcc_pkg::SETUP_CYC) begin
                        s.cnt = adcc_pkg::HALVES_FAST;
                    end else begin
                        s.cnt = adcc_pkg::HALVES_SLOW;
                    end
                end else if (r.cnt != 16'hffff) begin
                    s.cnt = r.cnt + 16'h0001;
                end
            end
            default: begin
                if (mck_rise_i || mck_fall_i) begin
                    s.cnt = r.cnt - 16'h0001;
                    if (r.cnt <= 16'h0001) begin
                        s.st = adcc_pkg::TS_IDLE;
                        s.busy = 1'b0;
                        s.is_cal = 1'b0;
                        s.done = 1'b1;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{st: adcc_pkg::TS_IDLE, cnt: 16'h0000, is_cal: 1'b0, busy: 1'b0, done: 1'b0};
        end else begin
            r <= s;
        end
    end
    assign busy_o = r.busy;
    assign cal_o = r.is_cal;
    assign done_o = r.done;

    property p_busy_on;
        @(posedge clk_i) disable iff (rst_i)
        (start_i && !busy_o) |=> busy_o;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy not raised");
    property p_fast;
        @(posedge clk_i) disable iff (rst_i)
        (r.st == adcc_pkg::TS_WAIT && mck_fall_i && !r.is_cal && r.cnt >= adcc_pkg::SETUP_CYC)
            |=> r.cnt == adcc_pkg::HALVES_FAST;
    endproperty
    a_fast: assert property (p_fast) else $error("short conversion length wrong");
    property p_done;
        @(posedge clk_i) disable iff (rst_i)
        $fell(busy_o) |-> done_o;
    endproperty
    a_done: assert property (p_done) else $error("busy fell without done");
endmodule : adcc_timer
`default_nettype wire

// ===== rtl/adcc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - ten host-readable and writable calibration registers: gain, offset, eight DAC
// - calibration runs load calibration registers without host access
// - select 00 all ten, 01 gain+offset, 10 offset, 11 gain
// - one selection and pointer serve reads and writes; host never mixes them
// - pointer resets on control write and after the last selected register
// - pointer starts at gain, or at offset for select 10
// - pointer advances after each complete register access
// - in byte mode pointer advances only after the high byte
// - host may abandon a sequence; next control write resets pointer
// - calibration reads return two leading zero bits
// - offset register is 14 data bits, defaulting near 0x2000
// - offset bits binary weighted, top bit 5 percent of reference
// - gain register 14 data bits, top bit 2.5 percent
// - conversion starts on start pin pulse or control convert bit
// - hold on start pin rising edge or end of control write
// - run begins next master clock fall; 16.5 or 17.5 periods by setup
// - busy goes low at end of conversion
// - busy falling clears convert bit; software may set it again
// - back to track on busy falling edge
// - first start after power-up runs self-calibration
// - busy status bit is one during conversion or calibration
module adcc_top #(
    parameter logic [15:0] CAL_HALVES = 16'h0040 // calibration length in master clock half periods
) (
    input wire logic CORE_CLK_I, // 40 MHz core clock
    input wire logic SYS_RST_I, // async reset, high
    input wire logic MASTER_CLOCK_IN_I, // master clock pin
    input wire logic CONVERT_START_N_I, // convert start pin, low pulse
    input wire logic CS_N_I, // chip select, low
    input wire logic RD_N_I, // read strobe, low
    input wire logic WR_N_I, // write strobe, low
    input wire logic HIGH_BYTE_SELECT_I, // byte mode: high byte
    input wire logic BYTE_MODE_I, // 1: 8-bit bus
    input wire logic [15:0] DB_I, // data bus in
    input wire logic [11:0] RESULT_I, // conversion result from core
    input wire logic CAL_WE_I, // calibration engine write
    input wire logic [3:0] CAL_IDX_I, // calibration engine index
    input wire logic [13:0] CAL_DATA_I, // calibration engine data
    output logic [15:0] DB_O, // data bus out
    output logic DB_OE_O, // data bus drive enable
    output logic BUSY_O, // conversion or calibration busy
    output logic HOLD_O, // 1: hold, 0: track
    output logic CAL_RUN_O // calibration running
);
    typedef struct packed {
        logic [2:0] mck;
        logic [2:0] cst;
        logic [1:0] cs;
        logic [2:0] rd;
        logic [2:0] wr;
        logic [1:0] hb;
        logic [1:0] bm;
        logic [15:0] db1;
        logic [15:0] db2;
        logic [15:0] wdat;
        logic [7:0] lo_byte;
        logic wr_cs;
        logic rd_cs;
        logic conv;
        logic stcal;
        logic [1:0] calsel;
        logic calmd;
        logic [1:0] rdt;
        logic first_done;
        logic hold;
        logic busy_q;
        logic [15:0] dout;
        logic doe;
    } adcc_top_st_t;
    adcc_top_st_t r, s;

    logic tmr_busy, tmr_cal, tmr_done;
    logic [15:0] cal_rd;
    logic [1:0] cal_sel;
    logic [3:0] cal_ptr;
    logic mck_rise, mck_fall, pin_start;
    logic wr_end, rd_end, rd_act, commit, ctl_wr, cal_wr;
    logic adv, ptr_rst, start, start_cal, busy_fall;
    logic [15:0] word, rd_word, st_word, ctl_word;

    always_comb begin
        s = r;
        // two-stage pin synchronisers, third stage only for edges
        s.mck = {r.mck[1:0], MASTER_CLOCK_IN_I};
        s.cst = {r.cst[1:0], CONVERT_START_N_I};
        s.cs = {r.cs[0], CS_N_I};
        s.rd = {r.rd[1:0], RD_N_I};
        s.wr = {r.wr[1:0], WR_N_I};
        s.hb = {r.hb[0], HIGH_BYTE_SELECT_I};
        s.bm = {r.bm[0], BYTE_MODE_I};
        s.db1 = DB_I;
        s.db2 = r.db1;
        mck_rise = r.mck[1] && !r.mck[2];
        mck_fall = !r.mck[1] && r.mck[2];
        pin_start = r.cst[1] && !r.cst[2];
        busy_fall = r.busy_q && !tmr_busy;
        s.busy_q = tmr_busy;

        // write strobe: data held while low, acted on at its end
        if (!r.wr[1] && !r.cs[1]) begin
            s.wr_cs = 1'b1;
            s.wdat = r.db2;
        end
        wr_end = r.wr_cs && r.wr[1] && !r.wr[2];
        if (wr_end) begin
            s.wr_cs = 1'b0;
        end
        commit = 1'b0;
        word = r.wdat;
        if (wr_end) begin
            if (!r.bm[1]) begin
                commit = 1'b1;
            end else if (!r.hb[1]) begin
                s.lo_byte = r.wdat[7:0];
            end else begin
                commit = 1'b1;
                word = {r.wdat[7:0], r.lo_byte};
            end
        end
        ctl_wr = commit && word[adcc_pkg::CTL_MARK];
        cal_wr = commit && (word[15:14] == 2'b00);
        ptr_rst = ctl_wr;
        // a control write steers the pointer reset with its own new selection
        cal_sel = ctl_wr ? word[adcc_pkg::CTL_CALSEL +: 2] : r.calsel;

        // read strobe
        rd_act = !r.rd[1] && !r.cs[1];
        if (rd_act) begin
            s.rd_cs = 1'b1;
        end
        rd_end = r.rd_cs && r.rd[1] && !r.rd[2];
        if (rd_end) begin
            s.rd_cs = 1'b0;
        end
        adv = cal_wr || (rd_end && r.rdt == adcc_pkg::RDT_CAL && (!r.bm[1] || r.hb[1]));

        // control register
        if (ctl_wr) begin
            s.calsel = word[adcc_pkg::CTL_CALSEL +: 2];
            s.calmd = word[adcc_pkg::CTL_CALMD];
            s.rdt = word[adcc_pkg::CTL_RDT +: 2];
        end
        start = 1'b0;
        start_cal = 1'b0;
        if (busy_fall) begin
            s.conv = 1'b0;
            s.stcal = 1'b0;
            s.hold = 1'b0;
        end
        if (ctl_wr && word[adcc_pkg::CTL_CONV]) begin
            s.conv = 1'b1;
        end
        if (ctl_wr && word[adcc_pkg::CTL_STCAL]) begin
            s.stcal = 1'b1;
        end
        if (!tmr_busy) begin
            if (ctl_wr && word[adcc_pkg::CTL_STCAL]) begin
                start = 1'b1;
                start_cal = 1'b1;
            end else if (pin_start || (ctl_wr && word[adcc_pkg::CTL_CONV])) begin
                start = 1'b1;
                start_cal = !r.first_done;
            end
        end
        if (start) begin
            s.first_done = 1'b1;
            s.hold = 1'b1;
        end

        // read data
        st_word = 16'h0000;
        st_word[adcc_pkg::ST_ONES +: 2] = 2'h3;
        st_word[adcc_pkg::ST_BUSY] = tmr_busy;
        st_word[adcc_pkg::ST_CALMD] = r.calmd;
        st_word[adcc_pkg::ST_CALSEL +: 2] = r.calsel;
        st_word[adcc_pkg::ST_STCAL] = tmr_cal;
        ctl_word = 16'h0000;
        ctl_word[adcc_pkg::CTL_MARK] = 1'b1;
        ctl_word[adcc_pkg::CTL_CONV] = r.conv;
        ctl_word[adcc_pkg::CTL_STCAL] = r.stcal;
        ctl_word[adcc_pkg::CTL_CALSEL +: 2] = r.calsel;
        ctl_word[adcc_pkg::CTL_CALMD] = r.calmd;
        ctl_word[adcc_pkg::CTL_RDT +: 2] = r.rdt;
        if (r.rdt == adcc_pkg::RDT_CAL) begin
            rd_word = cal_rd;
        end else if (r.rdt == adcc_pkg::RDT_STATUS) begin
            rd_word = st_word;
        end else if (r.rdt == adcc_pkg::RDT_CTRL) begin
            rd_word = ctl_word;
        end else begin
            rd_word = {4'h0, RESULT_I};
        end
        s.doe = rd_act;
        if (!rd_act) begin
            s.dout = 16'h0000;
        end else if (!r.bm[1]) begin
            s.dout = rd_word;
        end else if (r.hb[1]) begin
            s.dout = {8'h00, rd_word[15:8]};
        end else begin
            s.dout = {8'h00, rd_word[7:0]};
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            r <= '0;
            r.mck <= 3'h0;
            r.cst <= 3'h7;
            r.cs <= 2'h3;
            r.rd <= 3'h7;
            r.wr <= 3'h7;
        end else begin
            r <= s;
        end
    end

    adcc_calrf u_calrf (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .sel_i(cal_sel),
        .ptr_rst_i(ptr_rst),
        .adv_i(adv),
        .wr_i(cal_wr),
        .wr_data_i(word[13:0]),
        .hw_we_i(CAL_WE_I && tmr_cal),
        .hw_idx_i(CAL_IDX_I),
        .hw_data_i(CAL_DATA_I),
        .rd_data_o(cal_rd),
        .ptr_o(cal_ptr)
    );

    adcc_timer #(
        .CAL_HALVES(CAL_HALVES)
    ) u_timer (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .start_i(start),
        .cal_i(start_cal),
        .mck_rise_i(mck_rise),
        .mck_fall_i(mck_fall),
        .busy_o(tmr_busy),
        .cal_o(tmr_cal),
        .done_o(tmr_done)
    );

    assign DB_O = r.dout;
    assign DB_OE_O = r.doe;
    assign BUSY_O = tmr_busy;
    assign HOLD_O = r.hold;
    assign CAL_RUN_O = tmr_cal;

    property p_conv_clr;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (busy_fall && !(ctl_wr && word[adcc_pkg::CTL_CONV])) |=> !r.conv;
    endproperty
    a_conv_clr: assert property (p_conv_clr) else $error("convert bit not cleared");
    property p_track;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (tmr_done && !start) |=> !HOLD_O;
    endproperty
    a_track: assert property (p_track) else $error("not back in track");
    property p_first_cal;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (pin_start && !tmr_busy && !r.first_done) |=> CAL_RUN_O && BUSY_O;
    endproperty
    a_first_cal: assert property (p_first_cal) else $error("first start not calibration");
    property p_byte_adv;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (rd_end && r.bm[1] && !r.hb[1]) |-> !adv;
    endproperty
    a_byte_adv: assert property (p_byte_adv) else $error("advance on low byte");
    property p_hold;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (pin_start && !tmr_busy) |=> HOLD_O && BUSY_O;
    endproperty
    a_hold: assert property (p_hold) else $error("no hold after start edge");
    property p_ptr_rst;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ctl_wr |=> cal_ptr == (($past(word[adcc_pkg::CTL_CALSEL +: 2]) == adcc_pkg::SEL_OFS)
            ? adcc_pkg::IDX_OFFSET : adcc_pkg::IDX_GAIN);
    endproperty
    a_ptr_rst: assert property (p_ptr_rst) else $error("control write kept pointer");
    property p_sw_start;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (ctl_wr && word[adcc_pkg::CTL_CONV] && !tmr_busy) |=> HOLD_O && BUSY_O;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("no hold after software start");
    property p_sel_load;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ctl_wr |=> r.calsel == $past(word[adcc_pkg::CTL_CALSEL +: 2]);
    endproperty
    a_sel_load: assert property (p_sel_load) else $error("selection not taken");
endmodule : adcc_top
`default_nettype wire

// ===== dv/adcc_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_host (
    input wire logic clk_i, // core clock
    input wire logic [15:0] db_i, // read data from device
    output logic cs_n_o, // chip select, low
    output logic rd_n_o, // read strobe, low
    output logic wr_n_o, // write strobe, low
    output logic hbs_o, // high byte select
    output logic [15:0] db_o // write data
);
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        hbs_o = 1'b0;
        db_o = 16'h0000;
    end
    // strobes low 4 cycles, high at least 7, so each commit lands before the next access
    task automatic wr(input logic [15:0] w);
        wr_long(w, 4);
    endtask : wr
    // strobe held low for lo cycles, for a start that must outlast busy
    task automatic wr_long(input logic [15:0] w, input int lo);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        db_o = w;
        repeat (lo) @(negedge clk_i);
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
        db_o = ~w; // released bus shows no stale value
        repeat (6) @(negedge clk_i);
    endtask : wr_long
    task automatic rd(input logic hb, output logic [15:0] d);
        @(negedge clk_i);
        hbs_o = hb;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        repeat (5) @(negedge clk_i);
        d = db_i;
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : rd
endmodule : adcc_host
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst, mck, cst_n, byte_m, cal_we, cs_n, rd_n, wr_n, hbs, busy, hold, cal_run, oe;
    logic [3:0] cal_idx;
    logic [13:0] cal_data;
    logic [11:0] result;
    logic [15:0] hdb, db_o, got;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int falls = 0;
    int oe_cnt = 0;
    int n, k;
    logic [1:0] sel_tab [4] = '{adcc_pkg::SEL_ALL, adcc_pkg::SEL_GAIN_OFS, adcc_pkg::SEL_OFS, adcc_pkg::SEL_GAIN};
    logic [13:0] exp_tab [4][3] = '{'{14'h010a, 14'h0101, 14'h0102}, '{14'h010a, 14'h0101, 14'h010a},
        '{14'h0101, 14'h0101, 14'h0101}, '{14'h010a, 14'h010a, 14'h010a}};
    logic [7:0] b_exp [4] = '{8'h0a, 8'h0a, 8'h01, 8'h01};
    logic b_hb [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // master clock: 12 core cycles per period
    initial begin
        mck = 1'b0;
        forever #150 mck = ~mck;
    end

    adcc_top #(.CAL_HALVES(16'h0004)) i_adcc_top (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .MASTER_CLOCK_IN_I(mck), .CONVERT_START_N_I(cst_n),
        .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .HIGH_BYTE_SELECT_I(hbs), .BYTE_MODE_I(byte_m),
        .DB_I(hdb), .RESULT_I(result), .CAL_WE_I(cal_we), .CAL_IDX_I(cal_idx), .CAL_DATA_I(cal_data),
        .DB_O(db_o), .DB_OE_O(oe), .BUSY_O(busy), .HOLD_O(hold), .CAL_RUN_O(cal_run));
    adcc_host i_adcc_host (.clk_i(clk), .db_i(db_o), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .hbs_o(hbs), .db_o(hdb));

    always @(negedge mck) begin
        if (busy === 1'b1) begin
            falls++;
        end
    end
    always @(negedge clk) begin
        if (oe === 1'b1) begin
            oe_cnt++;
        end
    end

    function automatic logic [15:0] ctl(input logic [1:0] sel, input logic [1:0] rdt, input logic conv);
        ctl = (16'h0001 << adcc_pkg::CTL_MARK) | (16'(sel) << adcc_pkg::CTL_CALSEL)
            | (16'(rdt) << adcc_pkg::CTL_RDT) | 16'(conv);
    endfunction : ctl

    task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // start pin pulse released shortly after a master clock fall
    task automatic pulse();
        @(negedge mck);
        @(negedge clk);
        cst_n = 1'b0;
        repeat (3) @(negedge clk);
        cst_n = 1'b1;
    endtask : pulse

    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 400 && busy !== lvl; i++) begin
            @(negedge clk);
        end
    endtask : wait_busy

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        cst_n = 1'b1;
        byte_m = 1'b0;
        cal_we = 1'b0;
        cal_idx = 4'h0;
        cal_data = 14'h0000;
        result = 12'h5a3;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("busy after reset", {15'h0000, busy}, 16'h0000);
        i_adcc_host.wr(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_CAL, 1'b0));
        for (n = 0; n < 3; n++) begin
            i_adcc_host.rd(1'b0, got);
            chk("cal reset value", got, {2'b00, n == 0 ? adcc_pkg::GAIN_RST :
                (n == 1 ? adcc_pkg::OFFSET_RST : adcc_pkg::DAC_RST)});
        end
        $display("test reset done");
        // eleven writes: the last wraps back to gain
        i_adcc_host.wr(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_RESULT, 1'b0));
        for (n = 0; n < 11; n++) begin
            i_adcc_host.wr(16'h0100 + 16'(n));
        end
        for (n = 0; n < 4; n++) begin
            i_adcc_host.wr(ctl(sel_tab[n], adcc_pkg::RDT_CAL, 1'b0));
            for (k = 0; k < 3; k++) begin
                i_adcc_host.rd(1'b0, got);
                chk("cal read", got, {2'b00, exp_tab[n][k]});
            end
        end
        $display("test select table done");
        i_adcc_host.wr(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_CAL, 1'b0));
        byte_m = 1'b1;
        repeat (3) @(negedge clk);
        for (n = 0; n < 4; n++) begin
            i_adcc_host.rd(b_hb[n], got);
            chk("byte read", got, {8'h00, b_exp[n]});
        end
        byte_m = 1'b0;
        repeat (3) @(negedge clk);
        $display("test byte mode done");
        pulse();
        wait_busy(1'b1);
        chk("power-up calibration", {15'h0000, cal_run}, 16'h0001);
        cal_we = 1'b1;
        cal_idx = adcc_pkg::IDX_OFFSET;
        cal_data = 14'h1234;
        @(negedge clk);
        cal_we = 1'b0;
        wait_busy(1'b0);
        i_adcc_host.wr(ctl(adcc_pkg::SEL_OFS, adcc_pkg::RDT_CAL, 1'b0));
        i_adcc_host.rd(1'b0, got);
        chk("calibration update", got, 16'h1234);
        $display("test calibration done");
        falls = 0;
        pulse();
        wait_busy(1'b1);
        chk("hold in conversion", {15'h0000, hold}, 16'h0001);
        pulse();
        wait_busy(1'b0);
        chk("master falls in conversion", 16'(falls), 16'd17);
        repeat (2) @(negedge clk);
        chk("track after busy", {15'h0000, hold}, 16'h0000);
        repeat (30) @(negedge clk);
        chk("start during busy ignored", {15'h0000, busy}, 16'h0000);
        i_adcc_host.wr(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_RESULT, 1'b0));
        oe_cnt = 0;
        i_adcc_host.rd(1'b0, got);
        chk("result read", got, 16'h05a3);
        chk("drive cycles", 16'(oe_cnt), 16'd5);
        $display("test pin conversion done");
        i_adcc_host.wr(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_CTRL, 1'b1));
        wait_busy(1'b1);
        chk("software start", {15'h0000, busy & hold}, 16'h0001);
        i_adcc_host.wr_long(ctl(adcc_pkg::SEL_ALL, adcc_pkg::RDT_CTRL, 1'b1), 260);
        chk("stretched start", {15'h0000, busy}, 16'h0001);
        wait_busy(1'b0);
        i_adcc_host.rd(1'b0, got);
        chk("convert bit cleared", {15'h0000, got[adcc_pkg::CTL_CONV]}, 16'h0000);
        $display("test software start done");
        i_adcc_host.wr(ctl(adcc_pkg::SEL_GAIN, adcc_pkg::RDT_STATUS, 1'b0) | (16'h0001 << adcc_pkg::CTL_STCAL));
        i_adcc_host.rd(1'b0, got);
        chk("status in calibration", got, (16'h0003 << adcc_pkg::ST_ONES) | (16'h0001 << adcc_pkg::ST_BUSY)
            | (16'(adcc_pkg::SEL_GAIN) << adcc_pkg::ST_CALSEL) | (16'h0001 << adcc_pkg::ST_STCAL));
        wait_busy(1'b0);
        $display("test status done");
        pulse();
        wait_busy(1'b1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("busy and hold after mid reset", {14'h0000, busy, hold}, 16'h0000);
        pulse();
        wait_busy(1'b1);
        chk("calibration after reset", {15'h0000, cal_run}, 16'h0001);
        wait_busy(1'b0);
        $display("test mid-run reset done");
        test_done();
    end
endmodule : tb
`default_nettype wire
